// ===== rtl/nvs_regs.svh
// timing and layout constants for the nonvolatile sram host controller
// assumes a 25 MHz clock (40 ns period)
`ifndef NVS_REGS_SVH
`define NVS_REGS_SVH
`define NVS_CLK_PERIOD_NS 40
// precharge_min_time in ns, as a plain default
`define NVS_PRECHARGE_MIN_TIME_NS 60
// address_access_time in ns
`define NVS_ADDRESS_ACCESS_TIME_NS 60
// page (column) access time in ns
`define NVS_PAGE_ACCESS_TIME_NS 25
// write pulse width in ns
`define NVS_WRITE_PULSE_NS 40
// least times round up to whole cycles, never below one
`define NVS_CEIL_CYC(t) (((t) + `NVS_CLK_PERIOD_NS - 1) / `NVS_CLK_PERIOD_NS)
`define NVS_PC_CYC `NVS_CEIL_CYC(`NVS_PRECHARGE_MIN_TIME_NS)
`define NVS_AA_CYC `NVS_CEIL_CYC(`NVS_ADDRESS_ACCESS_TIME_NS)
`define NVS_AAP_CYC `NVS_CEIL_CYC(`NVS_PAGE_ACCESS_TIME_NS)
`define NVS_WP_CYC `NVS_CEIL_CYC(`NVS_WRITE_PULSE_NS)
// address field positions: row 16..2, column 1..0, byte lane 17
`define NVS_ROW_MSB 16
`define NVS_ROW_LSB 2
`define NVS_COL_MSB 1
`define NVS_BYTE_BIT 17
`define NVS_CNT_W 4
`endif

// ===== rtl/nvs_pkg.sv
// types shared by the nonvolatile sram host controller
package nvs_pkg;
   // user request: 18-bit byte address in byte mode, word address otherwise
   typedef struct packed {
      logic [17:0] addr;
      logic write;
      logic byte_mode;
      logic [15:0] wdata;
      logic [1:0] be;
   } nvs_req_t;
   // pins driven toward the memory
   typedef struct packed {
      logic [16:0] addr;
      logic chip_enable_n;
      logic write_enable_n;
      logic output_enable_n;
      logic upper_byte_select_n;
      logic lower_byte_select_n;
      logic sleep_request_n;
   } nvs_pins_t;
   typedef enum logic [2:0] {NVS_IDLE, NVS_ACCESS, NVS_WPULSE,
      NVS_DONE, NVS_PRECHARGE} nvs_state_t;
endpackage

// ===== rtl/nvs_host.sv
// host controller driving an asynchronous nonvolatile sram over its pins
// assumes pin inputs are synchronous to clk; one request at a time
`timescale 1ns/10ps
`include "nvs_regs.svh"

// What this block does
// - Write enable stays high through power-up and power-down.
// - In byte mode the lanes are joined and address bit 17 picks the lane.
// - A four-word page read costs the bus 4+3+3+3 clocks or more.
// - Chip enable stays low between accesses until an idle cycle with no request closes the row.
// - Precharge is chip enable high for at least the minimum time.
module nvs_host
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // user request side
   input wire nvs_pkg::nvs_req_t req,
   input wire logic req_valid,
   output logic req_ready,
   output logic [15:0] rdata,
   output logic rdata_valid,
   // memory pins
   output nvs_pkg::nvs_pins_t pins,
   output logic [15:0] dq_out,
   output logic [15:0] dq_oe,
   input wire logic [15:0] dq_in
);
   import nvs_pkg::*;

   localparam logic [`NVS_CNT_W-1:0] PC_CYC = `NVS_CNT_W'(`NVS_PC_CYC);
   localparam logic [`NVS_CNT_W-1:0] AA_CYC = `NVS_CNT_W'(`NVS_AA_CYC);
   localparam logic [`NVS_CNT_W-1:0] AAP_CYC = `NVS_CNT_W'(`NVS_AAP_CYC);
   localparam logic [`NVS_CNT_W-1:0] WP_CYC = `NVS_CNT_W'(`NVS_WP_CYC);

   nvs_state_t state_reg, state_next;
   logic [`NVS_CNT_W-1:0] cnt_reg, cnt_next;
   nvs_pins_t pins_reg, pins_next;
   logic [15:0] dq_out_reg, dq_out_next;
   logic [15:0] dq_oe_reg, dq_oe_next;
   logic [15:0] rdata_reg, rdata_next;
   logic rvalid_reg, rvalid_next;
   logic ready_reg, ready_next;
   logic row_open_reg, row_open_next;
   logic [16:0] waddr;
   logic [1:0] sel_n;
   logic [15:0] wdata;
   logic same_row;

   // map request onto word address, lanes and data
   always_comb
   begin
      if (req.byte_mode)
      begin
         waddr = req.addr[16:0];
         // lane chosen by bit 17; lanes are tied together
         sel_n = req.addr[`NVS_BYTE_BIT] ? 2'h1 : 2'h2;
         wdata = {req.wdata[7:0], req.wdata[7:0]};
      end
      else
      begin
         waddr = req.addr[16:0];
         sel_n = ~req.be;
         wdata = req.wdata;
      end
      // row compare on bits 16..2 only
      same_row = row_open_reg &&
         (waddr[`NVS_ROW_MSB:`NVS_ROW_LSB] ==
          pins_reg.addr[`NVS_ROW_MSB:`NVS_ROW_LSB]);
   end

   // sequencer: chip enable, strobes, timing counters
   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      pins_next = pins_reg;
      dq_out_next = dq_out_reg;
      dq_oe_next = dq_oe_reg;
      rdata_next = rdata_reg;
      rvalid_next = 1'b0;
      ready_next = ready_reg;
      row_open_next = row_open_reg;
      unique case (state_reg)
         NVS_IDLE:
         begin
            if (req_valid && ready_reg)
            begin
               ready_next = 1'b0;
               pins_next.addr = waddr;
               pins_next.chip_enable_n = 1'b0;
               pins_next.upper_byte_select_n = sel_n[1];
               pins_next.lower_byte_select_n = sel_n[0];
               pins_next.output_enable_n = req.write;
               // same row: column change only, short page time
               cnt_next = same_row ? AAP_CYC : AA_CYC;
               row_open_next = 1'b1;
               if (req.write)
               begin
                  dq_out_next = wdata;
                  dq_oe_next = {{8{~sel_n[1]}}, {8{~sel_n[0]}}};
                  pins_next.write_enable_n = 1'b0;
                  cnt_next = WP_CYC;
                  state_next = NVS_WPULSE;
               end
               else
               begin
                  dq_oe_next = 16'h0000;
                  state_next = NVS_ACCESS;
               end
            end
            else if (row_open_reg)
            begin
               // no queued work: close row, save standby current
               pins_next.chip_enable_n = 1'b1;
               pins_next.output_enable_n = 1'b1;
               row_open_next = 1'b0;
               cnt_next = PC_CYC;
               ready_next = 1'b0;
               state_next = NVS_PRECHARGE;
            end
         end
         NVS_ACCESS:
         begin
            // wait out the access time before sampling the bus
            if (cnt_reg <= `NVS_CNT_W'(1))
            begin
               rdata_next = dq_in;
               rvalid_next = 1'b1;
               state_next = NVS_DONE;
            end
            else
               cnt_next = cnt_reg - `NVS_CNT_W'(1);
         end
         NVS_WPULSE:
         begin
            if (cnt_reg <= `NVS_CNT_W'(1))
            begin
               // write ends on rising write enable, data held past it
               pins_next.write_enable_n = 1'b1;
               state_next = NVS_DONE;
            end
            else
               cnt_next = cnt_reg - `NVS_CNT_W'(1);
         end
         NVS_DONE:
         begin
            // chip enable stays low so the next column is a page access
            dq_oe_next = 16'h0000;
            pins_next.output_enable_n = 1'b1;
            ready_next = 1'b1;
            state_next = NVS_IDLE;
         end
         NVS_PRECHARGE:
         begin
            // chip enable high for the whole minimum time
            if (cnt_reg <= `NVS_CNT_W'(1))
            begin
               ready_next = 1'b1;
               state_next = NVS_IDLE;
            end
            else
               cnt_next = cnt_reg - `NVS_CNT_W'(1);
         end
      endcase
   end

   // register stage; reset leaves write enable and chip enable high
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= NVS_IDLE;
         cnt_reg <= '0;
         pins_reg <= '{addr: 17'h00000, chip_enable_n: 1'b1,
            write_enable_n: 1'b1, output_enable_n: 1'b1,
            upper_byte_select_n: 1'b1, lower_byte_select_n: 1'b1,
            sleep_request_n: 1'b1};
         dq_out_reg <= 16'h0000;
         dq_oe_reg <= 16'h0000;
         rdata_reg <= 16'h0000;
         rvalid_reg <= 1'b0;
         ready_reg <= 1'b1;
         row_open_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         pins_reg <= pins_next;
         dq_out_reg <= dq_out_next;
         dq_oe_reg <= dq_oe_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
         ready_reg <= ready_next;
         row_open_reg <= row_open_next;
      end
   end

   // outputs straight from flip-flops
   assign pins = pins_reg;
   assign dq_out = dq_out_reg;
   assign dq_oe = dq_oe_reg;
   assign rdata = rdata_reg;
   assign rdata_valid = rvalid_reg;
   assign req_ready = ready_reg;
endmodule

// ===== test/nvs_host_properties.sv
// checker for the nvs host request handshake and memory pins
// assumes it is bound onto nvs_host, one clock domain
`timescale 1ns/10ps
module nvs_host_chk
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // request side
   input wire nvs_pkg::nvs_req_t req,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic rdata_valid,
   // memory pins
   input wire nvs_pkg::nvs_pins_t pins,
   input wire logic [15:0] dq_oe
);
   import nvs_pkg::*;
   logic tk;
   assign tk = req_valid && req_ready;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   we_needs_ce_a:
      assert property (!pins.write_enable_n |-> !pins.chip_enable_n)
      else $error("write strobe low without chip enable");
   write_pulse_a:
      assert property (tk && req.write |-> ##[1:2] !pins.write_enable_n
         ##1 pins.write_enable_n ##[1:3] req_ready)
      else $error("write cycle out of budget");
   read_budget_a:
      assert property (tk && !req.write |-> ##[2:4] rdata_valid)
      else $error("read data late");
   byte_lane_a:
      assert property (tk && req.byte_mode && req.addr[17] |-> ##[1:2]
         !pins.upper_byte_select_n && pins.lower_byte_select_n)
      else $error("byte lane select wrong");
   precharge_a:
      assert property ($rose(pins.chip_enable_n) |-> pins.chip_enable_n[*2])
      else $error("precharge too short");
   idle_ce_a:
      assert property ((req_ready && !req_valid)[*3] |-> pins.chip_enable_n)
      else $error("chip enable low while idle");
   drive_dir_a:
      assert property (|dq_oe |-> pins.output_enable_n)
      else $error("data driven during read");
   cover property (tk && req.write);
   cover property (tk && req.byte_mode);
   cover property ($rose(pins.chip_enable_n));
endmodule
bind nvs_host nvs_host_chk u_chk (.clk, .rst_n, .req, .req_valid,
   .req_ready, .rdata_valid, .pins, .dq_oe);

// ===== test/nvs_mem_model.sv
// behavioural model of the nonvolatile memory behind nvs_host
// assumes pins come from the host; clockless, reads settle at once
`timescale 1ns/10ps
module nvs_mem_model
(
   // pins from the host
   input wire nvs_pkg::nvs_pins_t pins,
   input wire logic [15:0] dq_out,
   // data toward the host
   output logic [15:0] dq_in
);
   import nvs_pkg::*;
   logic [15:0] mem [0:131071]; // row 16..2, column 1..0
   logic [15:0] held = 16'h0;
   logic rd;
   // read access follows any address change with ce and oe held low and we high
   assign rd = !pins.chip_enable_n && !pins.output_enable_n
      && pins.write_enable_n;
   // unselected lanes show the inverse, never a stale copy
   always @*
   begin
      if (rd)
         held = mem[pins.addr];
      dq_in[15:8] = rd && !pins.upper_byte_select_n ? held[15:8] : ~held[15:8];
      dq_in[7:0] = rd && !pins.lower_byte_select_n ? held[7:0] : ~held[7:0];
   end
   // level write, each lane gated by its select
   always @(pins or dq_out)
      if (!pins.chip_enable_n && !pins.write_enable_n)
      begin
         if (!pins.upper_byte_select_n)
            mem[pins.addr][15:8] = dq_out[15:8];
         if (!pins.lower_byte_select_n)
            mem[pins.addr][7:0] = dq_out[7:0];
      end
endmodule

// ===== test/nvs_host_tb.sv
// self-checking bench for nvs_host driving the memory model
// assumes the model answers reads combinationally
`timescale 1ns/10ps
module nvs_host_tb;
   import nvs_pkg::*;
   logic clk, rst_n, req_valid, req_ready, rdata_valid;
   nvs_req_t req;
   nvs_pins_t pins;
   logic [15:0] rdata, dq_out, dq_oe, dq_in, q;
   int errors, samples_checked;
   nvs_host dut (.clk, .rst_n, .req, .req_valid, .req_ready, .rdata,
      .rdata_valid, .pins, .dq_out, .dq_oe, .dq_in);
   nvs_mem_model u_mem (.pins, .dq_out, .dq_in);
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic wrap_up;
      if (errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, exp);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one request; bounded waits for acceptance and read data
   task automatic xfer(input logic [17:0] a, input logic w, bm,
      input logic [15:0] d, input logic [1:0] be);
      int n;
      req <= '{a, w, bm, d, be};
      req_valid <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end while (req_ready !== 1'b1 && n < 40);
      req_valid <= 1'b0;
      // one edge passes even after a write, so valid never flips twice
      do
      begin
         @(posedge clk);
         n++;
      end while (!w && rdata_valid !== 1'b1 && n < 40);
      q = rdata;
      if (n >= 40)
      begin
         errors++;
         wrap_up;
      end
   endtask
   task automatic t_word;
      xfer(18'h00005, 1'b1, 1'b0, 16'h1234, 2'b11);
      xfer(18'h00005, 1'b1, 1'b0, 16'hABCD, 2'b01);
      xfer(18'h00005, 1'b0, 1'b0, 16'h0000, 2'b11);
      chk(q, 16'h12CD);
   endtask
   // a whole row written, read back from the last column down
   task automatic t_page;
      for (int i = 0; i < 4; i++)
         xfer(18'h00010 + 18'(i), 1'b1, 1'b0, 16'h5A00 | 16'(i), 2'b11);
      for (int i = 3; i >= 0; i--)
      begin
         xfer(18'h00010 + 18'(i), 1'b0, 1'b0, 16'h0000, 2'b11);
         chk(q, 16'h5A00 | 16'(i));
      end
   endtask
   task automatic t_byte;
      xfer(18'h20007, 1'b1, 1'b1, 16'h0077, 2'b11);
      xfer(18'h00007, 1'b1, 1'b1, 16'h0066, 2'b11);
      xfer(18'h00007, 1'b0, 1'b0, 16'h0000, 2'b11);
      chk(q, 16'h7766);
   endtask
   // row change back to back, then idle to let precharge run
   task automatic t_row_idle;
      xfer(18'h00011, 1'b0, 1'b0, 16'h0000, 2'b11);
      chk(q, 16'h5A01);
      xfer(18'h00005, 1'b0, 1'b0, 16'h0000, 2'b11);
      chk(q, 16'h12CD);
      // long enough for the idle chip enable property to see three cycles
      repeat (7) @(posedge clk);
      chk(16'(pins.chip_enable_n), 16'h0001);
      chk(dq_oe, 16'h0000);
   endtask
   initial
   begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req = '0;
      errors = 0;
      samples_checked = 0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      chk(16'(pins.write_enable_n), 16'h0001);
      @(posedge clk);
      t_word;
      t_page;
      t_byte;
      t_row_idle;
      wrap_up;
   end
endmodule
